// ==== ltec_top.sv ====
// Line start and exposure sequencer with AXI4-Lite registers and indicator
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// - Amber while initialising, then steady green.
// - Gate on: one line per accepted trigger.
// - Kind off: expose the full line period.
// - Polarity picks upward or downward transition.
// - Target select routes triggers to line begin.
// - Gate on: fixed, pulse-length, or no control.
// - Gate off: pulse-length exposure does not apply.
// - Fixed kind ends exposure after programmed duration.
// - Trigger origin selects any input line.
// - Pulse kind exposes while chosen level holds.
// - Blink green while triggers arrive.
module ltec_top #(
  parameter int BLINK_CYCLES = ltec_pkg::BLINK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ltec_pkg::NLINES-1:0] trig_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic line_begin_event,
  output logic exposure_active,
  output logic ind_amber,
  output logic ind_green
);
  import ltec_pkg::*;

  // Configuration registers
  ltec_ctrl_t ctrl_q, ctrl_d;
  logic [31:0] expo_q, expo_d;     // Exposure duration in cycles
  logic [31:0] period_q, period_d; // Internal line period in cycles
  // Bus handshake state
  logic awready_q, awready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Sequencer state
  logic [NLINES-1:0] sync_q;
  logic sel_q, sel_d;              // Previous sample of chosen line
  logic line_q, line_d;
  logic exp_q, exp_d;
  logic [31:0] cnt_q, cnt_d;       // Exposure cycle count
  logic [31:0] tmr_q, tmr_d;       // Internal line timer
  logic [15:0] lines_q, lines_d;   // Line counter shown in status
  // Indicator state
  ltec_ind_t ind_q, ind_d;
  logic [15:0] init_q, init_d;
  logic [31:0] act_q, act_d;       // Trigger activity window
  logic [31:0] div_q, div_d;       // Blink divider
  logic ph_q, ph_d;
  logic amber_q, amber_d;
  logic green_q, green_d;
  // Combinational helpers
  logic sel, rise, fall, start, held, wr_go, rd_go;
  logic [31:0] wmask;

  // Trigger lines cross into the clock domain first
  ltec_sync #(.W(NLINES)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(trig_in),
    .q(sync_q)
  );

  // Bus slave: write when address and data both wait, read one at a time
  always_comb begin
    wr_go = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    rd_go = s_axi_arvalid && !arready_q && !rvalid_q;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    ctrl_d = ctrl_q;
    expo_d = expo_q;
    period_d = period_q;
    awready_d = wr_go;
    arready_d = rd_go;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      // Only the low byte of the control word carries fields
      if (s_axi_awaddr == CTRL_OFS) begin
        if (s_axi_wstrb[0]) begin
          ctrl_d = ltec_ctrl_t'(s_axi_wdata[7:0]);
        end
      end else if (s_axi_awaddr == EXPO_OFS) begin
        expo_d = (expo_q & ~wmask) | (s_axi_wdata & wmask);
      end else if (s_axi_awaddr == PERIOD_OFS) begin
        period_d = (period_q & ~wmask) | (s_axi_wdata & wmask);
      end else if (s_axi_awaddr != STATUS_OFS) begin
        // Unmapped address answers an error; status writes are ignored
        bresp_d = RESP_SLVERR;
      end
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS: rdata_d = {24'h00_0000, ctrl_q};
        EXPO_OFS: rdata_d = expo_q;
        PERIOD_OFS: rdata_d = period_q;
        STATUS_OFS: rdata_d = {lines_q, 13'h0000, exp_q, green_q,
                               ind_q != IND_INIT};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // Line start and exposure decisions
  always_comb begin
    sel = sync_q[ctrl_q.origin];
    sel_d = sel;
    rise = sel && !sel_q;
    fall = !sel && sel_q;
    // High hold starts on the upward edge, low hold on the downward one
    held = (ctrl_q.pol == POL_HIGH) ? sel : !sel;
    start = 1'b0;
    tmr_d = 32'h0000_0000;
    if (ctrl_q.gate) begin
      if (ctrl_q.target) begin
        case (ctrl_q.pol)
          POL_UP, POL_HIGH: start = rise;
          POL_DOWN, POL_LOW: start = fall;
          default: start = 1'b0;
        endcase
      end
    end else if ((period_q == 32'h0000_0000) ||
                 (tmr_q >= period_q - 32'h0000_0001)) begin
      // A zero period behaves as one cycle instead of wrapping the compare
      start = 1'b1;
    end else begin
      tmr_d = tmr_q + 32'h0000_0001;
    end
    line_d = start;
    exp_d = exp_q;
    cnt_d = cnt_q;
    lines_d = start ? lines_q + 16'h0001 : lines_q;
    if (start) begin
      exp_d = 1'b1;
      cnt_d = 32'h0000_0001;
    end else if (exp_q) begin
      cnt_d = cnt_q + 32'h0000_0001;
      case (ltec_kind_t'(ctrl_q.kind))
        KIND_FIXED: begin
          if (cnt_q >= expo_q) begin
            exp_d = 1'b0;
            cnt_d = cnt_q;
          end
        end
        KIND_PULSE: begin
          // Gate off leaves pulse kind as full period exposure
          if (ctrl_q.gate && !held) begin
            exp_d = 1'b0;
          end
        end
        KIND_OFF: exp_d = 1'b1;
        default: exp_d = 1'b1;
      endcase
    end
  end

  // Indicator: amber until init ends, green blinking while triggers arrive
  always_comb begin
    ind_d = ind_q;
    init_d = init_q;
    act_d = (act_q != 32'h0000_0000) ? act_q - 32'h0000_0001 : act_q;
    div_d = div_q;
    ph_d = ph_q;
    if (ctrl_q.gate && start) begin
      act_d = 32'(2 * BLINK_CYCLES);
    end
    case (ind_q)
      IND_INIT: begin
        init_d = init_q + 16'h0001;
        if (init_q >= 16'(INIT_CYC - 1)) begin
          ind_d = IND_RUN;
        end
      end
      IND_RUN: begin
        div_d = 32'h0000_0000;
        ph_d = 1'b0;
        if (act_q != 32'h0000_0000) begin
          ind_d = IND_BLINK;
        end
      end
      IND_BLINK: begin
        // Blink rate is fixed, unrelated to the trigger rate
        if (div_q >= 32'(BLINK_CYCLES - 1)) begin
          div_d = 32'h0000_0000;
          ph_d = !ph_q;
        end else begin
          div_d = div_q + 32'h0000_0001;
        end
        if (act_q == 32'h0000_0000) begin
          ind_d = IND_RUN;
        end
      end
      default: ind_d = IND_INIT;
    endcase
    amber_d = (ind_d == IND_INIT);
    green_d = (ind_d == IND_RUN) || (ind_d == IND_BLINK && !ph_d);
  end

  // Register every group; synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ltec_ctrl_t'(CTRL_RST);
      expo_q <= EXPO_RST;
      period_q <= PERIOD_RST;
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      sel_q <= 1'b0;
      line_q <= 1'b0;
      exp_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
      tmr_q <= 32'h0000_0000;
      lines_q <= 16'h0000;
      ind_q <= IND_INIT;
      init_q <= 16'h0000;
      act_q <= 32'h0000_0000;
      div_q <= 32'h0000_0000;
      ph_q <= 1'b0;
      amber_q <= 1'b1;
      green_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      expo_q <= expo_d;
      period_q <= period_d;
      awready_q <= awready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      line_q <= line_d;
      exp_q <= exp_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      lines_q <= lines_d;
      ind_q <= ind_d;
      init_q <= init_d;
      act_q <= act_d;
      div_q <= div_d;
      ph_q <= ph_d;
      amber_q <= amber_d;
      green_q <= green_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign line_begin_event = line_q;
  assign exposure_active = exp_q;
  assign ind_amber = amber_q;
  assign ind_green = green_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_init_amber: assert property (
    (ind_q == IND_INIT) |-> (amber_q && !green_q))
    else $error("indicator not amber during init");
  a_init_green: assert property (
    $fell(amber_q) |-> green_q ##1 (green_q || ind_q == IND_BLINK))
    else $error("indicator not green after init");
  a_trig_line: assert property (
    (ctrl_q.gate && ctrl_q.target && ctrl_q.pol == POL_UP
     && sync_q[ctrl_q.origin] && !sel_q) |=> line_q ##1 !line_q)
    else $error("upward transition gave no single line start");
  a_timer_line: assert property (
    (!ctrl_q.gate && period_q > 32'h1 && line_q && $stable(ctrl_q))
      |=> !line_q)
    else $error("internal timer restarted too early");
  a_fixed_end: assert property (
    (exp_q && ctrl_q.kind == KIND_FIXED && cnt_q >= expo_q && !start)
      |=> !exp_q)
    else $error("fixed exposure overran");
  a_off_hold: assert property (
    (exp_q && ctrl_q.kind == KIND_OFF) |=> exp_q)
    else $error("exposure dropped with control off");
  a_pulse_end: assert property (
    (exp_q && ctrl_q.gate && ctrl_q.kind == KIND_PULSE
     && ctrl_q.pol == POL_HIGH && !sync_q[ctrl_q.origin] && !start)
      |=> !exp_q)
    else $error("pulse exposure outlived the level");
  a_nogate_pulse: assert property (
    (exp_q && !ctrl_q.gate && ctrl_q.kind == KIND_PULSE) |=> exp_q)
    else $error("pulse exposure applied with gate off");
  a_bresp_hold: assert property (
    (bvalid_q && !s_axi_bready) |=> (bvalid_q && $stable(bresp_q)))
    else $error("write answer dropped early");
  c_trig_line: cover property (ctrl_q.gate && line_q);
  c_blink: cover property (ind_q == IND_BLINK && $rose(ph_q));
  c_fixed_done: cover property (ctrl_q.kind == KIND_FIXED && $fell(exp_q));
endmodule : ltec_top

// ==== ltec_pkg.sv ====
// Package for the line trigger and exposure sequencer: map, fields, timing
package ltec_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] EXPO_OFS = 32'h0000_0004;
  localparam logic [31:0] PERIOD_OFS = 32'h0000_0008;
  localparam logic [31:0] STATUS_OFS = 32'h0000_000c;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] EXPO_RST = 32'h0000_03e8;
  localparam logic [31:0] PERIOD_RST = 32'h0000_07d0;
  // AXI answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Number of trigger input lines
  localparam int NLINES = 4;
  // Timing: clock period, init time, blink half period
  localparam int CLK_NS = 5;
  localparam int INIT_NS = 1000;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_NS = 100000;
  localparam int BLINK_CYC = BLINK_NS / CLK_NS;

  // Exposure control kinds
  typedef enum logic [1:0] {
    KIND_OFF = 2'b00,
    KIND_FIXED = 2'b01,
    KIND_PULSE = 2'b10
  } ltec_kind_t;

  // Trigger polarity selections
  typedef enum logic [1:0] {
    POL_UP = 2'b00,
    POL_DOWN = 2'b01,
    POL_HIGH = 2'b10,
    POL_LOW = 2'b11
  } ltec_pol_t;

  // Indicator states
  typedef enum logic [1:0] {
    IND_INIT = 2'b00,
    IND_RUN = 2'b01,
    IND_BLINK = 2'b10
  } ltec_ind_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic target;
    logic [1:0] origin;
    logic [1:0] pol;
    logic [1:0] kind;
    logic gate;
  } ltec_ctrl_t;
endpackage : ltec_pkg

// ==== ltec_sync.sv ====
// Two-flop synchroniser for the trigger input lines
`timescale 1ns/100ps
module ltec_sync #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage is read only by the second stage
  logic [W-1:0] meta_q;

  // Both stages clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ltec_sync

// ==== ltec_trig_src.sv ====
// Trigger source model that drives the camera trigger lines
`timescale 1ns/100ps
module ltec_trig_src (
  input wire logic aclk,
  output logic [ltec_pkg::NLINES-1:0] trig_in
);
  logic [ltec_pkg::NLINES-1:0] idle_q = '0; // Resting level per line
  logic [ltec_pkg::NLINES-1:0] mask_q = '0; // Line of the latest pulse
  int cyc_q = 0; // Free-running cycle count
  int end_q = 0; // Count at which the pulse is over
  // A pulse flips its line away from rest; each variable has one driver
  assign trig_in = idle_q ^ ((cyc_q < end_q) ? mask_q : '0);
  // Only this process moves the cycle count
  always @(posedge aclk) begin
    cyc_q <= cyc_q + 1;
  end
  // Callers space pulses wider than the programmed exposure
  task automatic fire(input int line, input int width);
    @(posedge aclk);
    mask_q <= 4'h1 << line;
    end_q <= cyc_q + 1 + width;
  endtask : fire
  // Move resting levels; used to set up downward or low pulses
  task automatic set_idle(input logic [3:0] m);
    @(posedge aclk);
    idle_q <= m;
  endtask : set_idle
endmodule : ltec_trig_src

// ==== test_ltec_top.sv ====
// Self-checking bench for the line trigger and exposure sequencer
`timescale 1ns/100ps
module test_ltec_top;
  import ltec_pkg::*;
  localparam int BLK = 8; // Short blink keeps the run brief
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [NLINES-1:0] trig_in;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lbe, expo, amber, green;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks = 0;
  always #2.5 aclk = ~aclk;
  ltec_top #(.BLINK_CYCLES(BLK)) u_ltec_top (.aclk(aclk),
    .aresetn(aresetn), .trig_in(trig_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_begin_event(lbe), .exposure_active(expo), .ind_amber(amber),
    .ind_green(green));
  ltec_trig_src u_ltec_trig_src (.aclk(aclk), .trig_in(trig_in));
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Slave never answered: count it and stop
  task automatic hang();
    n_mismatch++;
    $display("mismatch handshake expected answer seen none");
    complete_run();
  endtask : hang
  // Write; address and data are each released when taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) hang();
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : wr
  // Read and compare data and answer code
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask : rd
  // Cycles until a line begins; the launch cycle is counted too
  task automatic wl(input int lim, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (lbe !== 1'b1 && n < lim);
  endtask : wl
  // Cycles the exposure stays high, capped at lim
  task automatic el(input int lim, output int n);
    n = 0;
    while (expo === 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask : el
  function automatic logic [31:0] ctl(input logic [1:0] o, ltec_pol_t p,
                                      ltec_kind_t k, logic g);
    return {24'h0, 1'b1, o, p, k, g};
  endfunction : ctl
  task automatic t_init();
    int n;
    @(negedge aclk);
    chk("amber", 1, amber);
    chk("green", 0, green);
    n = 0;
    while (green !== 1'b1 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk("init_len", 1, n > INIT_CYC - 10 && n < INIT_CYC + 10);
    chk("amber_off", 0, amber);
    rd(CTRL_OFS, {24'h0, CTRL_RST}, RESP_OKAY);
    rd(EXPO_OFS, EXPO_RST, RESP_OKAY);
    rd(PERIOD_OFS, PERIOD_RST, RESP_OKAY);
    wr(STATUS_OFS, 32'hffff_ffff, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0003, RESP_OKAY);
    rd(32'h40, 32'h0, RESP_SLVERR);
    wr(32'h40, 32'h1, RESP_SLVERR);
    $display("test init done");
  endtask : t_init
  task automatic t_timer();
    int n;
    wr(EXPO_OFS, 32'h5, RESP_OKAY);
    wr(PERIOD_OFS, 32'h14, RESP_OKAY);
    wr(CTRL_OFS, ctl(2'd0, POL_UP, KIND_FIXED, 1'b0), RESP_OKAY);
    wl(3000, n);
    wl(40, n);
    chk("timer_gap", 20, n);
    el(20, n);
    chk("timer_expo", 5, n);
    // Gate off refuses pulse length: whole period is exposed
    wr(CTRL_OFS, ctl(2'd0, POL_HIGH, KIND_PULSE, 1'b0), RESP_OKAY);
    wl(40, n);
    el(50, n);
    chk("nogate_pulse", 50, n);
    $display("test timer done");
  endtask : t_timer
  task automatic t_trig();
    int n;
    ltec_pol_t pl;
    wr(EXPO_OFS, 32'h4, RESP_OKAY);
    for (int o = 0; o < NLINES; o++) begin
      for (int k = 0; k < 2; k++) begin
        pl = k ? POL_DOWN : POL_UP;
        wr(CTRL_OFS, ctl(2'(o), pl, KIND_FIXED, 1'b1), RESP_OKAY);
        u_ltec_trig_src.set_idle(k ? 4'h1 << o : 4'h0);
        repeat (6) @(posedge aclk);
        u_ltec_trig_src.fire(o, 2);
        wl(20, n);
        chk("trig_lat", 4, n);
        el(20, n);
        chk("fixed_expo", 4, n);
      end
    end
    // Target select away from line begin: a trigger starts nothing
    wr(CTRL_OFS, ctl(2'd3, POL_DOWN, KIND_FIXED, 1'b1) & 32'h0000_007f,
       RESP_OKAY);
    u_ltec_trig_src.fire(3, 2);
    wl(20, n);
    chk("no_target", 20, n);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_pulse();
    int n;
    u_ltec_trig_src.set_idle(4'h0);
    wr(CTRL_OFS, ctl(2'd0, POL_HIGH, KIND_PULSE, 1'b1), RESP_OKAY);
    repeat (6) @(posedge aclk);
    u_ltec_trig_src.fire(0, 7);
    wl(20, n);
    el(20, n);
    chk("high_hold", 7, n);
    u_ltec_trig_src.set_idle(4'h2);
    repeat (6) @(posedge aclk);
    wr(CTRL_OFS, ctl(2'd1, POL_LOW, KIND_PULSE, 1'b1), RESP_OKAY);
    repeat (6) @(posedge aclk);
    u_ltec_trig_src.fire(1, 6);
    wl(20, n);
    el(20, n);
    chk("low_hold", 6, n);
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_off_blink();
    int n;
    wr(CTRL_OFS, ctl(2'd2, POL_UP, KIND_OFF, 1'b1), RESP_OKAY);
    u_ltec_trig_src.set_idle(4'h0);
    repeat (40) @(posedge aclk);
    chk("steady", 1, green);
    u_ltec_trig_src.fire(2, 2);
    wl(20, n);
    el(40, n);
    chk("off_expo", 40, n);
    u_ltec_trig_src.fire(2, 2);
    n = 0;
    while (green === 1'b1 && n < 40) begin
      @(negedge aclk);
      n++;
    end
    chk("blink", 1, n <= 2 * BLK + 4);
    repeat (3 * BLK + 8) @(posedge aclk);
    chk("blink_end", 1, green);
    $display("test off and blink done");
  endtask : t_off_blink
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_init();
    t_timer();
    t_trig();
    t_pulse();
    t_off_blink();
    complete_run();
  end
endmodule : test_ltec_top
